// *** include/rcm_pkg.sv ***
package rcm_pkg;

    // Clock rate of clk_i, which is the oscillator rate before the divider.
    localparam int unsigned CLK_MHZ = 200;
    // The system clock output runs at the oscillator rate divided by this.
    localparam int unsigned SYS_DIV = 2;

    // Times in system clock output periods, as the pin behaviour is stated.
    localparam int unsigned RESET_TAIL_SYS = 2;
    localparam int unsigned MODE_GAP_SYS = 4;
    // First fetch after release, in half system clock periods (six and a half).
    localparam int unsigned FETCH_HALF_SYS = 13;
    localparam int unsigned WAIT_RESAMPLE_SYS = 5;
    localparam int unsigned MIN_RESET_SYS = 4;

    // Counter width and the derived counts of clk_i cycles.
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] RESET_TAIL_CYC = CNT_W'(RESET_TAIL_SYS * SYS_DIV);
    localparam logic [CNT_W-1:0] MODE_GAP_CYC = CNT_W'(MODE_GAP_SYS * SYS_DIV);
    localparam logic [CNT_W-1:0] FETCH_CYC = CNT_W'((FETCH_HALF_SYS * SYS_DIV) / 2);
    localparam logic [CNT_W-1:0] WAIT_CYC = CNT_W'(WAIT_RESAMPLE_SYS * SYS_DIV);
    localparam logic [CNT_W-1:0] MIN_RESET_CYC = CNT_W'(MIN_RESET_SYS * SYS_DIV);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Reset values of the control state.
    localparam logic RST_OUT_RESET = 1'b1;
    localparam logic RUN_RESET = 1'b0;
    localparam logic DIV_RESET = 1'b0;

    // Reset sequencer, Gray coded along dormant, release, run.
    typedef enum logic [1:0] {
        RCM_ST_DORMANT = 2'b00,
        RCM_ST_RELEASE = 2'b01,
        RCM_ST_RUN = 2'b11
    } rcm_seq_e;

    // Wait-gate machine, Gray coded along idle, suspend, done.
    typedef enum logic [1:0] {
        RCM_W_IDLE = 2'b00,
        RCM_W_SUSPEND = 2'b01,
        RCM_W_DONE = 2'b11
    } rcm_wait_e;

    // Mode selection state caught around the reset release.
    typedef struct packed {
        logic enhanced;
        logic valid;
        logic first_sample;
    } rcm_mode_s;

    localparam rcm_mode_s MODE_RESET = 3'h0;

endpackage

// *** src/rcm_top.sv ***
`timescale 1ns/1ps
// Function
// - System clock output is the oscillator clock divided by two.
// - System clock output has equal high and low times.
// - System clock output keeps toggling during reset and bus hold.
// - Reset output is active high, clocked, and lasts as long as reset input.
// - Reset output drops two system clock periods after reset input rises.
// - Reset output is always driven, never floated, also during hold.
// - Asserted reset input aborts activity, clears state, leaves the core dormant.
// - Reset input is asynchronous and passes a synchroniser before use.
// - First fetch starts six and a half clocks after reset input release.
// - Enhanced mode only if test pin high at release, low four clocks later.
// - Test pin is an input after reset; a weak pull-up holds it high.
// - Compatible mode wait suspends on test high, resamples every five clocks.
// - While suspended with interrupts enabled, pending interrupts are serviced.
// - Enhanced mode: coprocessor commands issue only once busy pin reads low.
module rcm_top (
    // Clock and power-on reset.
    input wire logic clk_i,
    input wire logic resetn_i,
    // Reset pin from the external reset circuit.
    input wire logic reset_in_n_i,
    // Shared test and busy pin.
    input wire logic test_busy_i,
    output logic test_busy_o,
    output logic test_busy_oe_o,
    // Clock and reset outputs to the system.
    output logic sys_clock_out_o,
    output logic reset_out_o,
    output logic reset_short_o,
    // Core control and mode status.
    output logic core_run_o,
    output logic fetch_start_o,
    output logic enhanced_mode_o,
    output logic mode_valid_o,
    // Wait instruction handshake from the core.
    input wire logic wait_start_i,
    input wire logic int_enable_i,
    input wire logic irq_pending_i,
    output logic wait_suspend_o,
    output logic wait_irq_service_o,
    output logic wait_done_o,
    // Coprocessor command handshake from the core.
    input wire logic fpu_cmd_req_i,
    output logic fpu_cmd_go_o,
    output logic fpu_busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Clock divider.

    logic div_d;
    logic div_q;

    // The divider sees only the power-on reset, so the output keeps running
    // while the reset pin is low and while the bus is held away.
    always_comb begin
        div_d = ~div_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= rcm_pkg::DIV_RESET;
        end else begin
            div_q <= div_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic rin_meta_q;
    logic rin_sync_q;
    logic tst_meta_q;
    logic tst_sync_q;

    // Only the second stage is read anywhere; the reset pin reads as asserted
    // until it has been seen high twice.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rin_meta_q <= 1'b0;
            rin_sync_q <= 1'b0;
            tst_meta_q <= 1'b1;
            tst_sync_q <= 1'b1;
        end else begin
            rin_meta_q <= reset_in_n_i;
            rin_sync_q <= rin_meta_q;
            tst_meta_q <= test_busy_i;
            tst_sync_q <= tst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer and mode selection.

    rcm_pkg::rcm_seq_e seq_d;
    rcm_pkg::rcm_seq_e seq_q;
    logic [rcm_pkg::CNT_W-1:0] cnt_d;
    logic [rcm_pkg::CNT_W-1:0] cnt_q;
    logic [rcm_pkg::CNT_W-1:0] low_d;
    logic [rcm_pkg::CNT_W-1:0] low_q;
    logic rst_out_d;
    logic rst_out_q;
    logic short_d;
    logic short_q;
    logic run_d;
    logic run_q;
    logic fetch_d;
    logic fetch_q;
    rcm_pkg::rcm_mode_s mode_d;
    rcm_pkg::rcm_mode_s mode_q;

    always_comb begin
        seq_d = seq_q;
        cnt_d = cnt_q;
        low_d = low_q;
        rst_out_d = rst_out_q;
        short_d = short_q;
        run_d = run_q;
        fetch_d = 1'b0;
        mode_d = mode_q;
        if (!rin_sync_q) begin
            // Everything except the low-time count low_q returns to its idle value while the pin is low.
            seq_d = rcm_pkg::RCM_ST_DORMANT;
            cnt_d = rcm_pkg::CNT_ZERO;
            rst_out_d = 1'b1;
            run_d = 1'b0;
            mode_d = rcm_pkg::MODE_RESET;
            short_d = 1'b0;
            if (low_q != rcm_pkg::MIN_RESET_CYC) begin
                low_d = low_q + rcm_pkg::CNT_ONE;
            end
        end else begin
            case (seq_q)
                rcm_pkg::RCM_ST_DORMANT: begin
                    seq_d = rcm_pkg::RCM_ST_RELEASE;
                    cnt_d = rcm_pkg::CNT_ONE;
                    mode_d.first_sample = tst_sync_q;
                    // A pulse shorter than the minimum is flagged, not refused.
                    short_d = (low_q != rcm_pkg::MIN_RESET_CYC);
                    low_d = rcm_pkg::CNT_ZERO;
                end
                rcm_pkg::RCM_ST_RELEASE: begin
                    cnt_d = cnt_q + rcm_pkg::CNT_ONE;
                    if (cnt_q == rcm_pkg::RESET_TAIL_CYC) begin
                        rst_out_d = 1'b0;
                    end
                    if (cnt_q == rcm_pkg::MODE_GAP_CYC) begin
                        mode_d.enhanced = mode_q.first_sample & ~tst_sync_q;
                        mode_d.valid = 1'b1;
                    end
                    if (cnt_q == rcm_pkg::FETCH_CYC) begin
                        fetch_d = 1'b1;
                        run_d = 1'b1;
                        seq_d = rcm_pkg::RCM_ST_RUN;
                    end
                end
                rcm_pkg::RCM_ST_RUN: begin
                    seq_d = rcm_pkg::RCM_ST_RUN;
                end
                default: begin
                    seq_d = rcm_pkg::RCM_ST_DORMANT;
                    rst_out_d = 1'b1;
                    run_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seq_q <= rcm_pkg::RCM_ST_DORMANT;
            cnt_q <= rcm_pkg::CNT_ZERO;
            low_q <= rcm_pkg::CNT_ZERO;
            rst_out_q <= rcm_pkg::RST_OUT_RESET;
            short_q <= 1'b0;
            run_q <= rcm_pkg::RUN_RESET;
            fetch_q <= 1'b0;
            mode_q <= rcm_pkg::MODE_RESET;
        end else begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            low_q <= low_d;
            rst_out_q <= rst_out_d;
            short_q <= short_d;
            run_q <= run_d;
            fetch_q <= fetch_d;
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wait-gate machine for compatible mode.

    rcm_pkg::rcm_wait_e wst_d;
    rcm_pkg::rcm_wait_e wst_q;
    logic [rcm_pkg::CNT_W-1:0] wcnt_d;
    logic [rcm_pkg::CNT_W-1:0] wcnt_q;
    logic susp_d;
    logic susp_q;
    logic irq_d;
    logic irq_q;
    logic irq_seen_d;
    logic irq_seen_q;
    logic done_d;
    logic done_q;

    always_comb begin
        wst_d = wst_q;
        wcnt_d = wcnt_q;
        susp_d = susp_q;
        irq_d = 1'b0;
        irq_seen_d = irq_seen_q & irq_pending_i;
        done_d = 1'b0;
        if (!rin_sync_q || !run_q) begin
            wst_d = rcm_pkg::RCM_W_IDLE;
            wcnt_d = rcm_pkg::CNT_ZERO;
            susp_d = 1'b0;
            irq_seen_d = 1'b0;
        end else begin
            case (wst_q)
                rcm_pkg::RCM_W_IDLE: begin
                    if (wait_start_i) begin
                        if (!mode_q.enhanced && tst_sync_q) begin
                            wst_d = rcm_pkg::RCM_W_SUSPEND;
                            wcnt_d = rcm_pkg::CNT_ONE;
                            susp_d = 1'b1;
                        end else begin
                            wst_d = rcm_pkg::RCM_W_DONE;
                        end
                    end
                end
                rcm_pkg::RCM_W_SUSPEND: begin
                    // One service pulse per pending request; the core drops
                    // the request on acceptance, which rearms the pulse.
                    if (int_enable_i && irq_pending_i && !irq_seen_q) begin
                        irq_d = 1'b1;
                        irq_seen_d = 1'b1;
                    end
                    if (wcnt_q == rcm_pkg::WAIT_CYC) begin
                        wcnt_d = rcm_pkg::CNT_ONE;
                        if (!tst_sync_q) begin
                            wst_d = rcm_pkg::RCM_W_DONE;
                            susp_d = 1'b0;
                        end
                    end else begin
                        wcnt_d = wcnt_q + rcm_pkg::CNT_ONE;
                    end
                end
                rcm_pkg::RCM_W_DONE: begin
                    done_d = 1'b1;
                    wst_d = rcm_pkg::RCM_W_IDLE;
                end
                default: begin
                    wst_d = rcm_pkg::RCM_W_IDLE;
                    susp_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wst_q <= rcm_pkg::RCM_W_IDLE;
            wcnt_q <= rcm_pkg::CNT_ZERO;
            susp_q <= 1'b0;
            irq_q <= 1'b0;
            irq_seen_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            wst_q <= wst_d;
            wcnt_q <= wcnt_d;
            susp_q <= susp_d;
            irq_q <= irq_d;
            irq_seen_q <= irq_seen_d;
            done_q <= done_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coprocessor command gate for enhanced mode.

    logic go_d;
    logic go_q;
    logic busy_d;
    logic busy_q;

    // The gate reads the synchronised pin, so a busy edge is seen two clocks
    // late; the coprocessor must raise busy before it can take another command.
    always_comb begin
        busy_d = run_q & mode_q.enhanced & tst_sync_q;
        go_d = fpu_cmd_req_i & run_q & mode_q.enhanced & ~tst_sync_q & ~go_q;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            go_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            go_q <= go_d;
            busy_q <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared pin driver.

    logic pin_out_q;
    logic pin_oe_q;

    // The device never drives the shared pin; the pull-up lives in the pad.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign sys_clock_out_o = div_q;
    assign reset_out_o = rst_out_q;
    assign reset_short_o = short_q;
    assign core_run_o = run_q;
    assign fetch_start_o = fetch_q;
    assign enhanced_mode_o = mode_q.enhanced;
    assign mode_valid_o = mode_q.valid;
    assign wait_suspend_o = susp_q;
    assign wait_irq_service_o = irq_q;
    assign wait_done_o = done_q;
    assign fpu_cmd_go_o = go_q;
    assign fpu_busy_o = busy_q;
    assign test_busy_o = pin_out_q;
    assign test_busy_oe_o = pin_oe_q;

endmodule // rcm_top

// *** tb/rcm_far_end.sv ***
`timescale 1ns/1ps
module rcm_far_end (
    // Oscillator clock and the device reset output.
    input wire logic clk_i,
    input wire logic reset_out_i,
    // Pin role: released, driven low, coprocessor busy, tied to reset output.
    input wire logic [1:0] pin_mode_i,
    // Reset pin and shared pin drive.
    output logic reset_in_n_o,
    output logic pin_drive_o,
    output logic pin_val_o
);
    initial reset_in_n_o = 1'b0;
    assign pin_drive_o = pin_mode_i != 2'h0;
    assign pin_val_o = pin_mode_i[1] & (pin_mode_i[0] ? reset_out_i : 1'b1);
    // The caller keeps the count above the minimum; a short pulse would raise the short flag.
    task automatic pulse_reset(input int n);
        @(negedge clk_i);
        reset_in_n_o = 1'b0;
        repeat (n) @(negedge clk_i);
        reset_in_n_o = 1'b1;
    endtask
endmodule // rcm_far_end

// *** tb/rcm_monitor.sv ***
`timescale 1ns/1ps
module rcm_monitor (
    // Clock and resets.
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reset_in_n_i,
    // Pin and mode status.
    input wire logic test_busy_i,
    input wire logic test_busy_oe_o,
    input wire logic sys_clock_out_o,
    input wire logic reset_out_o,
    input wire logic core_run_o,
    input wire logic fetch_start_o,
    input wire logic enhanced_mode_o,
    input wire logic mode_valid_o,
    // Wait and coprocessor handshakes.
    input wire logic wait_start_i,
    input wire logic wait_suspend_o,
    input wire logic fpu_cmd_req_i,
    input wire logic fpu_cmd_go_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////
    // A pin rise counts only when the low phase had raised the reset output.
    sequence s_rel;
        $rose(reset_in_n_i) && reset_out_o ##1 reset_in_n_i[*6];
    endsequence
    sequence s_ready;
        s_rel ##1 reset_in_n_i[*8];
    endsequence
    property p_clk_run;
        $changed(sys_clock_out_o) |=> $changed(sys_clock_out_o);
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock output stalled");
    property p_rst_tail;
        s_rel |-> reset_out_o ##1 !reset_out_o;
    endproperty
    a_rst_tail: assert property (p_rst_tail) else $error("reset tail wrong");
    property p_dormant;
        (!reset_in_n_i)[*4] |-> reset_out_o && !core_run_o && !mode_valid_o;
    endproperty
    a_dormant: assert property (p_dormant) else $error("not dormant");
    property p_mode_time;
        s_rel ##1 reset_in_n_i[*4] |-> !mode_valid_o ##1 mode_valid_o;
    endproperty
    a_mode_time: assert property (p_mode_time) else $error("mode decided late");
    property p_mode_hold;
        mode_valid_o && reset_in_n_i |=> $stable(enhanced_mode_o);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
    property p_fetch;
        s_ready |-> !core_run_o ##2 fetch_start_o && core_run_o ##1 !fetch_start_o;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch start wrong");
    property p_pin_in;
        test_busy_oe_o == 1'b0;
    endproperty
    a_pin_in: assert property (p_pin_in) else $error("test pin driven");
    property p_wait_sus;
        test_busy_i[*3] ##0 (wait_start_i && core_run_o && mode_valid_o && !enhanced_mode_o
            && !wait_suspend_o) |=> wait_suspend_o;
    endproperty
    a_wait_sus: assert property (p_wait_sus) else $error("wait not suspended");
    // The earliest resample is ten clocks after entry, so ten samples stay high.
    property p_wait_len;
        $rose(wait_suspend_o) |-> wait_suspend_o[*8] ##1 wait_suspend_o[*2];
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("resample too early");
    property p_fpu_go;
        (!test_busy_i)[*3] ##0 (fpu_cmd_req_i && core_run_o && enhanced_mode_o
            && !fpu_cmd_go_o) |=> fpu_cmd_go_o;
    endproperty
    a_fpu_go: assert property (p_fpu_go) else $error("command not issued");
    property p_fpu_mode;
        fpu_cmd_go_o |-> enhanced_mode_o && $past(fpu_cmd_req_i);
    endproperty
    a_fpu_mode: assert property (p_fpu_mode) else $error("stray command");
endmodule // rcm_monitor

bind rcm_top rcm_monitor rcm_monitor_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .reset_in_n_i(reset_in_n_i), .test_busy_i(test_busy_i), .test_busy_oe_o(test_busy_oe_o),
    .sys_clock_out_o(sys_clock_out_o), .reset_out_o(reset_out_o), .core_run_o(core_run_o),
    .fetch_start_o(fetch_start_o), .enhanced_mode_o(enhanced_mode_o),
    .mode_valid_o(mode_valid_o), .wait_start_i(wait_start_i), .wait_suspend_o(wait_suspend_o),
    .fpu_cmd_req_i(fpu_cmd_req_i), .fpu_cmd_go_o(fpu_cmd_go_o));

// *** tb/test_reset_clock_mode_select.sv ***
`timescale 1ns/1ps
module test_reset_clock_mode_select;
    logic clk_i, resetn_i, wait_start_i, int_enable_i, irq_pending_i, fpu_cmd_req_i;
    logic [1:0] pin_mode;
    logic rin_n, drv, val, pin, t_o, t_oe, sclk, rst_o, run, fetch, enh, mval;
    logic wsus, wirq, wdone, go, fbusy, prev, rshort;
    int fails, tests_run, n, k;
    // A released pin reads high through the weak pull-up.
    assign pin = t_oe ? t_o : (drv ? val : 1'b1);
    rcm_far_end rcm_far_end_i (.clk_i(clk_i), .reset_out_i(rst_o), .pin_mode_i(pin_mode),
        .reset_in_n_o(rin_n), .pin_drive_o(drv), .pin_val_o(val));
    rcm_top rcm_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .reset_in_n_i(rin_n),
        .test_busy_i(pin), .test_busy_o(t_o), .test_busy_oe_o(t_oe), .sys_clock_out_o(sclk),
        .reset_out_o(rst_o), .reset_short_o(rshort), .core_run_o(run), .fetch_start_o(fetch),
        .enhanced_mode_o(enh), .mode_valid_o(mval), .wait_start_i(wait_start_i),
        .int_enable_i(int_enable_i), .irq_pending_i(irq_pending_i), .wait_suspend_o(wsus),
        .wait_irq_service_o(wirq), .wait_done_o(wdone), .fpu_cmd_req_i(fpu_cmd_req_i),
        .fpu_cmd_go_o(go), .fpu_busy_o(fbusy));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Enhanced needs the pin high at release and low four system clocks later.
    function automatic logic exp_mode(input logic [1:0] s);
        return (s != 2'h1) & s[0];
    endfunction
    // The pin passes two sync stages before a resample can see it low.
    // Resamples fall every wait period after entry; done shows one edge after the resample.
    function automatic int exp_done(input int d);
        int w;
        w = int'(rcm_pkg::WAIT_CYC);
        return (d == 0) ? 2 : (d + 1 + w) / w * w + 2;
    endfunction
    task automatic do_reset(input logic [1:0] s);
        int t_rst, t_mode, t_fetch, n_fetch;
        pin_mode = s;
        rcm_far_end_i.pulse_reset(9 + int'($urandom % 12));
        check({rst_o, run, mval}, 16'h4, "dormant");
        t_rst = 0;
        t_mode = 0;
        t_fetch = 0;
        n_fetch = 0;
        for (int i = 1; i <= 24; i++) begin
            @(negedge clk_i);
            if (rst_o === 1'b0 && t_rst == 0) t_rst = i;
            if (mval === 1'b1 && t_mode == 0) t_mode = i;
            if (fetch === 1'b1) begin
                n_fetch++;
                t_fetch = i;
            end
        end
        // Two sync stages and the edge that leaves dormant come before the counts.
        check(16'(t_rst), 16'(rcm_pkg::RESET_TAIL_CYC) + 16'h3, "reset tail");
        check(16'(t_mode), 16'(rcm_pkg::MODE_GAP_CYC) + 16'h3, "mode time");
        check(16'(t_fetch), 16'(rcm_pkg::FETCH_CYC) + 16'h3, "fetch time");
        check(16'(n_fetch), 16'h1, "fetch pulse");
        check({run, enh}, {15'h1, exp_mode(s)}, "mode");
        check(16'(rshort), 16'h0, "short flag");
        if (t_fetch == 0) wrap_up();
    endtask
    task automatic do_wait(input int d);
        int t_done, n_irq, n_go;
        pin_mode = (d == 0) ? 2'h1 : 2'h0;
        int_enable_i = 1'($urandom % 2);
        fpu_cmd_req_i = 1'b1;
        repeat (3) @(negedge clk_i);
        wait_start_i = 1'b1;
        t_done = 0;
        n_irq = 0;
        n_go = 0;
        for (int i = 1; i <= 60 && t_done == 0; i++) begin
            @(negedge clk_i);
            wait_start_i = 1'b0;
            if (i == d) pin_mode = 2'h1;
            irq_pending_i = (i >= 4 && i < 8);
            if (i == 2) check(16'(wsus), 16'(d != 0), "suspend");
            n_irq += int'(wirq === 1'b1);
            n_go += int'(go === 1'b1);
            if (wdone === 1'b1) t_done = i;
        end
        check(16'(t_done), 16'(exp_done(d)), "wait done");
        check(16'(n_irq), 16'(int_enable_i & (d != 0)), "irq service");
        check(16'(n_go), 16'h0, "compatible go");
        fpu_cmd_req_i = 1'b0;
        if (t_done == 0) wrap_up();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        resetn_i = 1'b0;
        wait_start_i = 1'b0;
        int_enable_i = 1'b0;
        irq_pending_i = 1'b0;
        fpu_cmd_req_i = 1'b0;
        pin_mode = 2'h0;
        fails = 0;
        tests_run = 0;
        void'($urandom(32'h77c6));
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        n = 0;
        prev = sclk;
        for (k = 0; k < 8; k++) begin
            @(negedge clk_i);
            n += int'(sclk !== prev);
            prev = sclk;
        end
        check(16'(n), 16'h8, "clock in reset");
        for (k = 0; k < 4; k++) do_reset(2'(k));
        // Busy must be seen through the synchroniser before a request is raised.
        pin_mode = 2'h2;
        repeat (3) @(negedge clk_i);
        fpu_cmd_req_i = 1'b1;
        n = 0;
        repeat (8) begin
            @(negedge clk_i);
            n += int'(go === 1'b1);
        end
        check(16'(n), 16'h0, "busy refused");
        check(16'(fbusy), 16'h1, "busy seen");
        pin_mode = 2'h1;
        k = 0;
        while (k < 8 && go !== 1'b1) begin
            @(negedge clk_i);
            k++;
        end
        fpu_cmd_req_i = 1'b0;
        check(16'(k), 16'h3, "go latency");
        pin_mode = 2'h0;
        repeat (8) @(negedge clk_i);
        check(16'(enh), 16'h1, "mode held");
        check(16'({t_oe, t_o}), 16'h0, "pin released");
        do_reset(2'h2);
        do_wait(0);
        do_wait(3 + int'($urandom % 25));
        wrap_up();
    end
endmodule // test_reset_clock_mode_select
